/* File: hw/ctm_consts.svh */
`ifndef CTM_CONSTS_SVH
`define CTM_CONSTS_SVH

// Register byte offsets.
`define CTM_OFS_ENABLE 12'h000
`define CTM_OFS_CONTROL 12'h004
`define CTM_OFS_COUNT 12'h008
`define CTM_OFS_CMP_A 12'h00C
`define CTM_OFS_CMP_P 12'h010
`define CTM_OFS_STATUS 12'h014

// Field positions.
`define CTM_BIT_ENABLE 0
`define CTM_BIT_FLAG_A 0
`define CTM_BIT_FLAG_P 1

// Reset values.
`define CTM_RST_CONTROL 8'h00
`define CTM_RST_CMP_A 10'h000
`define CTM_RST_CMP_P 3'h0

// Counter geometry: full period and period step, in timer clocks.
`define CTM_FULL_COUNT 11'h400
`define CTM_STEP_SHIFT 7

`endif

/* File: hw/ctm_pkg.sv */
`default_nettype none

package ctm_pkg;

  typedef enum logic [1:0] {
    CTM_MODE_COMPARE = 2'b00,
    CTM_MODE_UNDEF = 2'b01,
    CTM_MODE_PWM = 2'b10,
    CTM_MODE_TIMER = 2'b11
  } ctm_mode_t;

  // Layout of the second control register, bit 7 down to bit 0.
  typedef struct packed {
    ctm_mode_t mode_select;
    logic [1:0] output_action_select;
    logic output_initial_level;
    logic output_invert;
    logic period_duty_swap;
    logic clear_source_select;
  } ctm_control_t;

endpackage

`default_nettype wire

/* File: hw/ctm_timer.sv */
// Overview of operation
// - Mode 00 selects compare-match output.
// - Mode 11 selects timer/counter.
// - Mode 10 selects PWM output.
// - Clear on P match; zero P overflows.
// - Clear-by-P raises both match flags.
// - Clear-by-A: clear on A, no P flag.
// - Clear-by-A, zero A: overflow, no flag.
// - Compare pin changes only on A match or enable rise.
// - A match sets, clears or toggles pin.
// - Action codes: keep, low, high, toggle.
// - Enable rise loads initial pin level.
// - Enable rise zeroes counter; fall holds it.
// - Timer mode counts, never drives pin.
// - PWM ignores clear select; period, duty.
// - Swap 0: period from P, duty A.
// - Swap 1: period from A, duty P.
// - Duty at or above period: full.
// - PWM raises A and P flags.
// - PWM polarity and pass/force selection.
// - PWM actions: inactive, active, waveform.
// - Invert bit inverts pin waveform.
// - Forced pin keeps PWM counting running.
// - P compares counter bits nine to seven.
`include "ctm_consts.svh"
`default_nettype none

module ctm_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic count_tick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tm_out,
  output logic tm_out_en
);

  // A three-bit code scaled to 128-clock multiples, zero meaning the full count.
  function automatic logic [10:0] p_count(input logic [2:0] code);
    p_count = (code == 3'h0) ? `CTM_FULL_COUNT : {1'b0, code, 7'h00};
  endfunction

  logic counter_enable_reg;
  logic enable_prev_reg;
  ctm_pkg::ctm_control_t control_reg;
  logic [9:0] compare_a_value_reg;
  logic [2:0] compare_p_value_reg;
  logic match_a_flag_reg;
  logic match_p_flag_reg;
  logic [9:0] count_reg;
  logic out_level_reg;
  logic [31:0] prdata_reg;
  logic tm_out_reg;
  logic tm_out_en_reg;

  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic enable_rise;
  logic running;
  logic is_pwm;
  logic is_compare;
  logic [10:0] count_inc;
  logic match_a_raw;
  logic match_p_raw;
  logic a_set;
  logic p_set;
  logic clear_ev;
  logic [10:0] duty_val;
  logic [10:0] period_val;
  logic pwm_active;
  logic a_clear_w1;
  logic p_clear_w1;
  logic tm_out_next;
  logic tm_out_en_next;
  logic [31:0] read_next;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign pready = access;
  assign pslverr = access && !mapped;
  assign prdata = prdata_reg;

  always_comb
  begin
    mapped = 1'b1;
    read_next = 32'h0000_0000;
    unique case (paddr)
      `CTM_OFS_ENABLE: read_next[`CTM_BIT_ENABLE] = counter_enable_reg;
      `CTM_OFS_CONTROL: read_next[7:0] = control_reg;
      `CTM_OFS_COUNT: read_next[9:0] = count_reg;
      `CTM_OFS_CMP_A: read_next[9:0] = compare_a_value_reg;
      `CTM_OFS_CMP_P: read_next[2:0] = compare_p_value_reg;
      `CTM_OFS_STATUS:
      begin
        read_next[`CTM_BIT_FLAG_A] = match_a_flag_reg;
        read_next[`CTM_BIT_FLAG_P] = match_p_flag_reg;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle and presented in the access phase.
  always_ff @(posedge mclk)
  begin
    if (rst)
      prdata_reg <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata_reg <= read_next;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      counter_enable_reg <= 1'b0;
      control_reg <= `CTM_RST_CONTROL;
      compare_a_value_reg <= `CTM_RST_CMP_A;
      compare_p_value_reg <= `CTM_RST_CMP_P;
    end
    else if (wr)
    begin
      unique case (paddr)
        `CTM_OFS_ENABLE: counter_enable_reg <= pwdata[`CTM_BIT_ENABLE];
        `CTM_OFS_CONTROL: control_reg <= pwdata[7:0];
        `CTM_OFS_CMP_A: compare_a_value_reg <= pwdata[9:0];
        `CTM_OFS_CMP_P: compare_p_value_reg <= pwdata[2:0];
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      enable_prev_reg <= 1'b0;
    else
      enable_prev_reg <= counter_enable_reg;
  end

  assign enable_rise = counter_enable_reg && !enable_prev_reg;
  assign running = counter_enable_reg && !enable_rise && count_tick;
  assign is_pwm = control_reg.mode_select == ctm_pkg::CTM_MODE_PWM;
  assign is_compare = control_reg.mode_select == ctm_pkg::CTM_MODE_COMPARE;

  // Matches look at the value the counter is about to take; the full count wraps to zero.
  assign count_inc = {1'b0, count_reg} + 11'h001;
  assign match_a_raw = count_inc[9:0] == compare_a_value_reg;
  assign match_p_raw = (count_inc[9:7] == compare_p_value_reg) && (count_inc[6:0] == 7'h00);

  always_comb
  begin
    if (is_pwm)
    begin
      a_set = running && match_a_raw;
      p_set = running && match_p_raw;
      clear_ev = control_reg.period_duty_swap ? match_a_raw : match_p_raw;
    end
    else
    begin
      // Compare, timer and the undefined code all share this clearing scheme.
      a_set = running && match_a_raw &&
        !(control_reg.clear_source_select && compare_a_value_reg == 10'h000);
      p_set = running && match_p_raw && !control_reg.clear_source_select;
      clear_ev = control_reg.clear_source_select ? match_a_raw : match_p_raw;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      count_reg <= 10'h000;
    else if (enable_rise)
      count_reg <= 10'h000;
    else if (running && clear_ev)
      count_reg <= 10'h000;
    else if (running)
      count_reg <= count_inc[9:0];
  end

  assign a_clear_w1 = wr && paddr == `CTM_OFS_STATUS && pwdata[`CTM_BIT_FLAG_A];
  assign p_clear_w1 = wr && paddr == `CTM_OFS_STATUS && pwdata[`CTM_BIT_FLAG_P];

  // Flags are sticky and cleared by writing one; a match in the same cycle wins.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      match_a_flag_reg <= 1'b0;
      match_p_flag_reg <= 1'b0;
    end
    else
    begin
      match_a_flag_reg <= a_set || (match_a_flag_reg && !a_clear_w1);
      match_p_flag_reg <= p_set || (match_p_flag_reg && !p_clear_w1);
    end
  end

  // Compare-mode pin level before the invert bit.
  always_ff @(posedge mclk)
  begin
    if (rst)
      out_level_reg <= 1'b0;
    else if (enable_rise)
      out_level_reg <= control_reg.output_initial_level;
    else if (is_compare && a_set)
    begin
      unique case (control_reg.output_action_select)
        2'b00: out_level_reg <= out_level_reg;
        2'b01: out_level_reg <= 1'b0;
        2'b10: out_level_reg <= 1'b1;
        2'b11: out_level_reg <= !out_level_reg;
      endcase
    end
  end

  always_comb
  begin
    if (control_reg.period_duty_swap)
    begin
      period_val = (compare_a_value_reg == 10'h000) ? `CTM_FULL_COUNT :
        {1'b0, compare_a_value_reg};
      duty_val = p_count(compare_p_value_reg);
    end
    else
    begin
      period_val = p_count(compare_p_value_reg);
      duty_val = {1'b0, compare_a_value_reg};
    end
  end

  // Active from the counter clear until the duty match, or always if duty covers the period.
  assign pwm_active = (duty_val >= period_val) || ({1'b0, count_reg} < duty_val);

  always_comb
  begin
    tm_out_next = 1'b0;
    tm_out_en_next = 1'b0;
    unique case (control_reg.mode_select)
      ctm_pkg::CTM_MODE_COMPARE:
      begin
        tm_out_en_next = 1'b1;
        tm_out_next = out_level_reg ^ control_reg.output_invert;
      end
      ctm_pkg::CTM_MODE_PWM:
      begin
        tm_out_en_next = 1'b1;
        // Codes 00, 01 and 11 only force the pin; counting and flags carry on.
        unique case (control_reg.output_action_select)
          2'b01: tm_out_next = control_reg.output_initial_level;
          2'b10: tm_out_next = pwm_active ~^ control_reg.output_initial_level;
          default: tm_out_next = !control_reg.output_initial_level;
        endcase
        tm_out_next = tm_out_next ^ control_reg.output_invert;
      end
      default: tm_out_en_next = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tm_out_reg <= 1'b0;
      tm_out_en_reg <= 1'b0;
    end
    else
    begin
      tm_out_reg <= tm_out_next;
      tm_out_en_reg <= tm_out_en_next;
    end
  end

  assign tm_out = tm_out_reg;
  assign tm_out_en = tm_out_en_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_enable_rise_zero:
    assert property (enable_rise |=> count_reg == 10'h000)
      else $error("Counter not zeroed on enable rise.");
  chk_hold_when_off:
    assert property (!counter_enable_reg |=> count_reg == $past(count_reg))
      else $error("Counter moved while disabled.");
  chk_count_step:
    assert property (running && !clear_ev |=> count_reg == $past(count_inc[9:0]))
      else $error("Counter did not step by one.");
  chk_clear_a_no_p:
    assert property (!is_pwm && control_reg.clear_source_select && !match_p_flag_reg |=>
      !match_p_flag_reg)
      else $error("P flag event while clearing by A.");
  chk_zero_a_flag:
    assert property (!is_pwm && control_reg.clear_source_select &&
      compare_a_value_reg == 10'h000 ##1 match_a_flag_reg |-> $past(match_a_flag_reg))
      else $error("A flag set with zero compare A.");
  chk_action_low:
    assert property (is_compare && a_set && !enable_rise &&
      control_reg.output_action_select == 2'b01 |=> !out_level_reg)
      else $error("Drive-low action failed.");
  chk_p_leaves_pin:
    assert property (is_compare && p_set && !a_set && !enable_rise |=> $stable(out_level_reg))
      else $error("P match changed the pin.");
  chk_initial_level:
    assert property (enable_rise |=> out_level_reg == $past(control_reg.output_initial_level))
      else $error("Initial level not loaded.");
  chk_timer_no_drive:
    assert property (control_reg.mode_select == ctm_pkg::CTM_MODE_TIMER |=> !tm_out_en)
      else $error("Pin driven in timer mode.");
  chk_pwm_full_duty:
    assert property (is_pwm && control_reg.output_action_select == 2'b10 &&
      duty_val >= period_val |=> tm_out == $past(control_reg.output_initial_level ^
      control_reg.output_invert))
      else $error("Full duty not produced.");
  chk_flag_sticky:
    assert property (match_a_flag_reg && !a_clear_w1 |=> match_a_flag_reg)
      else $error("Match A flag lost.");

  cov_pwm_period: cover property (is_pwm && running && clear_ev);
  cov_toggle: cover property (is_compare && a_set && control_reg.output_action_select == 2'b11);
  cov_set_beats_clear: cover property (a_set && a_clear_w1);
  cov_overflow: cover property (running && count_reg == 10'h3FF);

endmodule

`default_nettype wire

/* File: dv/ctm_tb.sv */
`include "ctm_consts.svh"
`default_nettype none

`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, count_tick, psel, penable, pwrite, pready, pslverr, tm_out, tm_out_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic rerr;
  int mismatches = 0;
  int cmp_count = 0;
  logic [1:0] acts [3] = '{2'h0, 2'h1, 2'h2};
  logic inits [3] = '{1'h1, 1'h1, 1'h0};
  logic exps [3] = '{1'h1, 1'h0, 1'h1};

  ctm_timer ctm_timer_inst (.mclk(mclk), .rst(rst), .count_tick(count_tick), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tm_out(tm_out), .tm_out_en(tm_out_en));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic summarize();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Setup cycle, then access phase held until pready is sampled high.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
    begin
      mismatches++;
      summarize();
    end
    else
    begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    `CHK(rdat, e)
  endtask

  // Holds the timer clock enable for n edges, then lets the pin settle.
  task automatic tick(input int n);
    @(posedge mclk);
    count_tick <= 1'b1;
    repeat (n) @(posedge mclk);
    count_tick <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] act,
    input logic i, input logic v, input logic s, input logic c);
    return {24'h0, m, act, i, v, s, c};
  endfunction

  // Disables, programs, clears flags and enables, so each run starts from a rising enable.
  task automatic start(input logic [31:0] c, input logic [9:0] a, input logic [2:0] p);
    wr(`CTM_OFS_ENABLE, 32'h0);
    wr(`CTM_OFS_CONTROL, c);
    wr(`CTM_OFS_CMP_A, {22'h0, a});
    wr(`CTM_OFS_CMP_P, {29'h0, p});
    wr(`CTM_OFS_STATUS, 32'h3);
    wr(`CTM_OFS_ENABLE, 32'h1);
    // The pin register lags the loaded level by one edge, so wait one more.
    repeat (3) @(posedge mclk);
  endtask

  // Pin probed at t1 and t2 ticks, then at t1 into the next period; clear select held high.
  task automatic pwm(input logic s, input logic v, input logic [1:0] act, input logic i,
    input logic [9:0] a, input logic [2:0] p, input int t1, input int t2, input int per,
    input logic e1, input logic e2, input logic [1:0] st);
    start(ctl(2'h2, act, i, v, s, 1'h1), a, p);
    `CHK(tm_out_en, 1'b1)
    tick(t1);
    `CHK(tm_out, e1)
    tick(t2 - t1);
    `CHK(tm_out, e2)
    tick(per + t1 - t2);
    `CHK(tm_out, e1)
    rdc(`CTM_OFS_STATUS, {30'h0, st});
  endtask

  initial
  begin
    rst = 1'b1;
    count_tick = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rdc(`CTM_OFS_CONTROL, 32'h0);
    rdc(`CTM_OFS_CMP_A, 32'h0);
    rdc(`CTM_OFS_CMP_P, 32'h0);
    rdc(`CTM_OFS_STATUS, 32'h0);
    wr(`CTM_OFS_COUNT, 32'h5);
    rdc(`CTM_OFS_COUNT, 32'h0);
    `CHK(tm_out_en, 1'b1)
    xfer(12'h018, 1'b0, 32'h0);
    `CHK(rerr, 1'b1)
    `CHK(rdat, 32'h0)
    start(ctl(2'h0, 2'h3, 1'h0, 1'h0, 1'h0, 1'h0), 10'h00A, 3'h1);
    tick(5);
    rdc(`CTM_OFS_COUNT, 32'h5);
    tick(5);
    `CHK(tm_out, 1'b1)
    rdc(`CTM_OFS_STATUS, 32'h1);
    tick(118);
    rdc(`CTM_OFS_COUNT, 32'h0);
    rdc(`CTM_OFS_STATUS, 32'h3);
    `CHK(tm_out, 1'b1)
    wr(`CTM_OFS_STATUS, 32'h1);
    rdc(`CTM_OFS_STATUS, 32'h2);
    tick(10);
    `CHK(tm_out, 1'b0)
    wr(`CTM_OFS_ENABLE, 32'h0);
    tick(3);
    rdc(`CTM_OFS_COUNT, 32'hA);
    wr(`CTM_OFS_ENABLE, 32'h1);
    repeat (3) @(posedge mclk);
    rdc(`CTM_OFS_COUNT, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      start(ctl(2'h0, acts[k], inits[k], 1'h0, 1'h0, 1'h0), 10'h00A, 3'h1);
      `CHK(tm_out, inits[k])
      tick(10);
      `CHK(tm_out, exps[k])
    end
    start(ctl(2'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1), 10'h12C, 3'h1);
    tick(300);
    rdc(`CTM_OFS_COUNT, 32'h0);
    rdc(`CTM_OFS_STATUS, 32'h1);
    start(ctl(2'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1), 10'h000, 3'h1);
    tick(1023);
    rdc(`CTM_OFS_COUNT, 32'h3FF);
    tick(1);
    rdc(`CTM_OFS_COUNT, 32'h0);
    rdc(`CTM_OFS_STATUS, 32'h0);
    start(ctl(2'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0), 10'h3E8, 3'h0);
    tick(1024);
    rdc(`CTM_OFS_COUNT, 32'h0);
    rdc(`CTM_OFS_STATUS, 32'h3);
    start(ctl(2'h3, 2'h3, 1'h1, 1'h0, 1'h0, 1'h0), 10'h00A, 3'h1);
    `CHK(tm_out_en, 1'b0)
    tick(10);
    rdc(`CTM_OFS_STATUS, 32'h1);
    pwm(1'h0, 1'h0, 2'h2, 1'h1, 10'h020, 3'h1, 16, 48, 128, 1'h1, 1'h0, 2'h3);
    pwm(1'h1, 1'h0, 2'h2, 1'h1, 10'h100, 3'h1, 100, 200, 256, 1'h1, 1'h0, 2'h3);
    pwm(1'h0, 1'h0, 2'h2, 1'h1, 10'h0C8, 3'h1, 16, 100, 128, 1'h1, 1'h1, 2'h2);
    pwm(1'h0, 1'h1, 2'h2, 1'h1, 10'h020, 3'h1, 16, 48, 128, 1'h0, 1'h1, 2'h3);
    pwm(1'h0, 1'h0, 2'h2, 1'h0, 10'h020, 3'h1, 16, 48, 128, 1'h0, 1'h1, 2'h3);
    pwm(1'h0, 1'h0, 2'h0, 1'h1, 10'h020, 3'h1, 16, 48, 128, 1'h0, 1'h0, 2'h3);
    pwm(1'h0, 1'h0, 2'h1, 1'h1, 10'h020, 3'h1, 16, 48, 128, 1'h1, 1'h1, 2'h3);
    pwm(1'h0, 1'h0, 2'h2, 1'h1, 10'h12C, 3'h3, 200, 350, 384, 1'h1, 1'h0, 2'h3);
    summarize();
  end
endmodule

`default_nettype wire
